// file: eccdp_pkg.sv
// shared constants for the error-corrected true dual-port memory
package eccdp_pkg;

  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int DATA_W  = 8;
  localparam int CODE_W  = 13;
  localparam int DEPTH   = 16;
  localparam int ADDR_W  = 4;
  localparam int SYN_W   = 4;
  localparam int NPORT   = 2;
  localparam int PORT_A  = 0;
  localparam int PORT_B  = 1;
  localparam int LATENCY = 4;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  localparam int AXI_ADDR_W = 4;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = AXI_DATA_W / 8;
  localparam int CNT_W      = 8;
  localparam int NCNT       = 4;

  localparam logic [AXI_ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] REG_COUNT  = 4'h8;

  localparam int CTRL_INJECT_BIT = 0;
  localparam logic CTRL_INJECT_RESET = 1'h0;

  // status: per port {valid, uncorrectable, found, fixed}, port b one nibble up
  localparam int STAT_PORT_STRIDE = 4;
  localparam int STAT_FIXED_BIT   = 0;
  localparam int STAT_FOUND_BIT   = 1;
  localparam int STAT_FATAL_BIT   = 2;
  localparam int STAT_VALID_BIT   = 3;

  // count: a fixed, b fixed, a fatal, b fatal, one byte each
  localparam int CNT_A_FIXED = 0;
  localparam int CNT_B_FIXED = 1;
  localparam int CNT_A_FATAL = 2;
  localparam int CNT_B_FATAL = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: eccdp_codec.sv
// one port's encoder and decoder, one pipeline stage each
`timescale 1ns/1ps
module eccdp_codec #(
  parameter int DATA_W = eccdp_pkg::DATA_W,
  parameter int CODE_W = eccdp_pkg::CODE_W,
  parameter int SYN_W  = eccdp_pkg::SYN_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              inject,
  output logic      [CODE_W-1:0] wr_code,
  input  wire logic [CODE_W-1:0] rd_code,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   fixed_flag,
  output logic                   found_flag,
  output logic                   fatal_flag
);
  import eccdp_pkg::*;

  // ---------------------------------------------------------------
  // hamming code over positions 1..CODE_W-1, overall parity in bit 0
  // ---------------------------------------------------------------
  function automatic logic [CODE_W-1:0] encode(input logic [DATA_W-1:0] d);
    logic [CODE_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < SYN_W; b++) begin
      for (int p = 1; p < CODE_W; p++) begin
        if (((p >> b) & 1) == 1 && p != (1 << b)) begin
          c[1 << b] = c[1 << b] ^ c[p];
        end
      end
    end
    c[0] = ^c[CODE_W-1:1];
    return c;
  endfunction

  function automatic logic [DATA_W-1:0] extract(input logic [CODE_W-1:0] c);
    logic [DATA_W-1:0] d;
    int k;
    d = '0;
    k = 0;
    for (int p = 1; p < CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p];
        k++;
      end
    end
    return d;
  endfunction

  // ---------------------------------------------------------------
  // encode and decode stages
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] code_reg,  code_next;
  logic [DATA_W-1:0] data_reg,  data_next;
  logic              fixed_reg, fixed_next;
  logic              found_reg, found_next;
  logic              fatal_reg, fatal_next;

  always_comb begin
    logic [SYN_W-1:0]  syn;
    logic              par;
    logic [CODE_W-1:0] fix;
    syn = '0;
    par = ^rd_code;
    fix = rd_code;
    code_next = encode(wr_data);
    code_next[0] = code_next[0] ^ inject;
    for (int p = 1; p < CODE_W; p++) begin
      if (rd_code[p]) begin
        syn = syn ^ SYN_W'(p);
      end
    end
    // flags as logic, not branches, so an unknown stored word gives unknown flags
    fixed_next = par & (syn < SYN_W'(CODE_W));
    found_next = par | (syn != '0);
    fatal_next = found_next & ~fixed_next;
    if (fixed_next) begin
      fix[syn] = ~fix[syn];
    end
    data_next = extract(fix);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_reg  <= '0;
      data_reg  <= '0;
      fixed_reg <= 1'b0;
      found_reg <= 1'b0;
      fatal_reg <= 1'b0;
    end else begin
      code_reg  <= code_next;
      data_reg  <= data_next;
      fixed_reg <= fixed_next;
      found_reg <= found_next;
      fatal_reg <= fatal_next;
    end
  end

  assign wr_code    = code_reg;
  assign rd_data    = data_reg;
  assign fixed_flag = fixed_reg;
  assign found_flag = found_reg;
  assign fatal_flag = fatal_reg;

endmodule

// file: eccdp_top.sv
// error-corrected true dual-port memory with an axi4-lite control slave
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module eccdp_top (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [eccdp_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [eccdp_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [eccdp_pkg::AXI_STRB_W-1:0] s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic      [1:0]                       s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [eccdp_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic      [eccdp_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                       s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic                             port_a_lsb_inject,
  input  wire logic [eccdp_pkg::ADDR_W-1:0]     port_a_addr,
  input  wire logic [eccdp_pkg::DATA_W-1:0]     port_a_wr_data,
  input  wire logic                             port_a_wr_en,
  input  wire logic                             port_a_rd_en,
  input  wire logic [eccdp_pkg::ADDR_W-1:0]     port_b_addr,
  input  wire logic [eccdp_pkg::DATA_W-1:0]     port_b_wr_data,
  input  wire logic                             port_b_wr_en,
  input  wire logic                             port_b_rd_en,
  output logic      [eccdp_pkg::DATA_W-1:0]     port_a_read_word,
  output logic                                  port_a_fixed_flag,
  output logic                                  port_a_found_flag,
  output logic                                  port_a_uncorrectable_flag,
  output logic      [eccdp_pkg::DATA_W-1:0]     port_b_read_word,
  output logic                                  port_b_fixed_flag,
  output logic                                  port_b_found_flag,
  output logic                                  port_b_uncorrectable_flag
);
  import eccdp_pkg::*;

  // ---------------------------------------------------------------
  // per-port wiring
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] in_addr  [NPORT];
  logic [DATA_W-1:0] in_data  [NPORT];
  logic              in_we    [NPORT];
  logic              in_re    [NPORT];
  logic              inject   [NPORT];
  logic [CODE_W-1:0] enc_code [NPORT];
  logic [DATA_W-1:0] dec_data [NPORT];
  logic              dec_fix  [NPORT];
  logic              dec_find [NPORT];
  logic              dec_fatal[NPORT];
  logic              ctrl_inject_reg;

  assign in_addr[PORT_A] = port_a_addr;
  assign in_data[PORT_A] = port_a_wr_data;
  assign in_we[PORT_A]   = port_a_wr_en;
  assign in_re[PORT_A]   = port_a_rd_en;
  assign in_addr[PORT_B] = port_b_addr;
  assign in_data[PORT_B] = port_b_wr_data;
  assign in_we[PORT_B]   = port_b_wr_en;
  assign in_re[PORT_B]   = port_b_rd_en;
  // software may force injection too; only port a can corrupt its writes
  assign inject[PORT_A]  = port_a_lsb_inject | ctrl_inject_reg;
  assign inject[PORT_B]  = 1'b0;

  // ---------------------------------------------------------------
  // encoders and decoders, one pair per port
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] q_reg [NPORT];

  for (genvar g = 0; g < NPORT; g++) begin : g_port
    eccdp_codec u_codec (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .wr_data    (in_data[g]),
      .inject     (inject[g]),
      .wr_code    (enc_code[g]),
      .rd_code    (q_reg[g]),
      .rd_data    (dec_data[g]),
      .fixed_flag (dec_fix[g]),
      .found_flag (dec_find[g]),
      .fatal_flag (dec_fatal[g])
    );
  end

  assign port_a_read_word          = dec_data[PORT_A];
  assign port_a_fixed_flag         = dec_fix[PORT_A];
  assign port_a_found_flag         = dec_find[PORT_A];
  assign port_a_uncorrectable_flag = dec_fatal[PORT_A];
  assign port_b_read_word          = dec_data[PORT_B];
  assign port_b_fixed_flag         = dec_fix[PORT_B];
  assign port_b_found_flag         = dec_find[PORT_B];
  assign port_b_uncorrectable_flag = dec_fatal[PORT_B];

  // ---------------------------------------------------------------
  // control pipeline: skew stage, array input stage, valid tracking
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] s1_addr_reg[NPORT], s1_addr_next[NPORT];
  logic              s1_we_reg  [NPORT], s1_we_next  [NPORT];
  logic              s1_re_reg  [NPORT], s1_re_next  [NPORT];
  logic [ADDR_W-1:0] m_addr_reg [NPORT], m_addr_next [NPORT];
  logic              m_we_reg   [NPORT], m_we_next   [NPORT];
  logic              m_re_reg   [NPORT], m_re_next   [NPORT];
  logic [CODE_W-1:0] m_code_reg [NPORT], m_code_next [NPORT];
  logic              qv_reg     [NPORT], qv_next     [NPORT];
  logic              dv_reg     [NPORT], dv_next     [NPORT];

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      s1_addr_next[p] = in_addr[p];
      s1_we_next[p]   = in_we[p];
      s1_re_next[p]   = in_re[p];
      m_addr_next[p]  = s1_addr_reg[p];
      m_we_next[p]    = s1_we_reg[p];
      m_re_next[p]    = s1_re_reg[p];
      m_code_next[p]  = enc_code[p];
      qv_next[p]      = m_re_reg[p];
      dv_next[p]      = qv_reg[p];
    end
  end

  always_ff @(posedge aclk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (!aresetn) begin
        s1_addr_reg[p] <= '0;
        s1_we_reg[p]   <= 1'b0;
        s1_re_reg[p]   <= 1'b0;
        m_addr_reg[p]  <= '0;
        m_we_reg[p]    <= 1'b0;
        m_re_reg[p]    <= 1'b0;
        m_code_reg[p]  <= '0;
        qv_reg[p]      <= 1'b0;
        dv_reg[p]      <= 1'b0;
      end else begin
        s1_addr_reg[p] <= s1_addr_next[p];
        s1_we_reg[p]   <= s1_we_next[p];
        s1_re_reg[p]   <= s1_re_next[p];
        m_addr_reg[p]  <= m_addr_next[p];
        m_we_reg[p]    <= m_we_next[p];
        m_re_reg[p]    <= m_re_next[p];
        m_code_reg[p]  <= m_code_next[p];
        qv_reg[p]      <= qv_next[p];
        dv_reg[p]      <= dv_next[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // storage array and registered read outputs
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] mem_reg [DEPTH];
  logic [CODE_W-1:0] mem_next[DEPTH];
  logic [CODE_W-1:0] q_next  [NPORT];

  always_comb begin
    mem_next = mem_reg;
    for (int p = 0; p < NPORT; p++) begin
      if (m_we_reg[p]) begin
        mem_next[m_addr_reg[p]] = m_code_reg[p];
      end
    end
    // a write collision has no defined winner
    if (m_we_reg[PORT_A] && m_we_reg[PORT_B] && m_addr_reg[PORT_A] == m_addr_reg[PORT_B]) begin
      mem_next[m_addr_reg[PORT_A]] = {CODE_W{1'bx}};
    end
    for (int p = 0; p < NPORT; p++) begin
      q_next[p] = q_reg[p];
      if (m_re_reg[p]) begin
        q_next[p] = mem_reg[m_addr_reg[p]];
      end
    end
    if (m_re_reg[PORT_A] && m_we_reg[PORT_A]) begin
      q_next[PORT_A] = m_code_reg[PORT_A];
    end
  end

  // the array itself is not cleared by reset, only its output registers
  always_ff @(posedge aclk) begin
    mem_reg <= mem_next;
  end

  always_ff @(posedge aclk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (!aresetn) begin
        q_reg[p] <= '0;
      end else begin
        q_reg[p] <= q_next[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // error counters: the event wins over a clearing write
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt_reg [NCNT];
  logic [CNT_W-1:0] cnt_next[NCNT];
  logic             cnt_event[NCNT];
  logic             cnt_clear;

  assign cnt_event[CNT_A_FIXED] = dv_reg[PORT_A] & dec_fix[PORT_A];
  assign cnt_event[CNT_B_FIXED] = dv_reg[PORT_B] & dec_fix[PORT_B];
  assign cnt_event[CNT_A_FATAL] = dv_reg[PORT_A] & dec_fatal[PORT_A];
  assign cnt_event[CNT_B_FATAL] = dv_reg[PORT_B] & dec_fatal[PORT_B];

  always_comb begin
    for (int i = 0; i < NCNT; i++) begin
      cnt_next[i] = cnt_clear ? '0 : cnt_reg[i];
      if (cnt_event[i] && cnt_next[i] != '1) begin
        cnt_next[i] = cnt_next[i] + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < NCNT; i++) begin
      if (!aresetn) begin
        cnt_reg[i] <= '0;
      end else begin
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave, one write and one read in flight
  // ---------------------------------------------------------------
  logic                  awready_reg, awready_next;
  logic                  wready_reg,  wready_next;
  logic                  bvalid_reg,  bvalid_next;
  logic [1:0]            bresp_reg,   bresp_next;
  logic                  aw_have_reg, aw_have_next;
  logic                  w_have_reg,  w_have_next;
  logic [AXI_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [AXI_DATA_W-1:0] w_data_reg,  w_data_next;
  logic [AXI_STRB_W-1:0] w_strb_reg,  w_strb_next;
  logic                  arready_reg, arready_next;
  logic                  rvalid_reg,  rvalid_next;
  logic [1:0]            rresp_reg,   rresp_next;
  logic [AXI_DATA_W-1:0] rdata_reg,   rdata_next;
  logic                  ctrl_inject_next;
  logic [AXI_DATA_W-1:0] status_word, count_word;

  always_comb begin
    status_word = '0;
    count_word  = '0;
    for (int p = 0; p < NPORT; p++) begin
      status_word[p*STAT_PORT_STRIDE+STAT_FIXED_BIT] = dec_fix[p];
      status_word[p*STAT_PORT_STRIDE+STAT_FOUND_BIT] = dec_find[p];
      status_word[p*STAT_PORT_STRIDE+STAT_FATAL_BIT] = dec_fatal[p];
      status_word[p*STAT_PORT_STRIDE+STAT_VALID_BIT] = dv_reg[p];
    end
    for (int i = 0; i < NCNT; i++) begin
      count_word[i*CNT_W +: CNT_W] = cnt_reg[i];
    end
  end

  always_comb begin
    aw_have_next     = aw_have_reg;
    w_have_next      = w_have_reg;
    aw_addr_next     = aw_addr_reg;
    w_data_next      = w_data_reg;
    w_strb_next      = w_strb_reg;
    bvalid_next      = bvalid_reg;
    bresp_next       = bresp_reg;
    ctrl_inject_next = ctrl_inject_reg;
    cnt_clear        = 1'b0;
    if (s_axi_awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      case (aw_addr_reg[AXI_ADDR_W-1:2])
        REG_CTRL[AXI_ADDR_W-1:2]: begin
          if (w_strb_reg[0]) begin
            ctrl_inject_next = w_data_reg[CTRL_INJECT_BIT];
          end
        end
        REG_STATUS[AXI_ADDR_W-1:2]: begin
          bresp_next = RESP_OKAY;
        end
        REG_COUNT[AXI_ADDR_W-1:2]: begin
          cnt_clear = 1'b1;
        end
        default: begin
          bresp_next = RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_have_next && !bvalid_next;
    wready_next  = !w_have_next && !bvalid_next;

    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = '0;
      case (s_axi_araddr[AXI_ADDR_W-1:2])
        REG_CTRL[AXI_ADDR_W-1:2]: begin
          rdata_next[CTRL_INJECT_BIT] = ctrl_inject_reg;
        end
        REG_STATUS[AXI_ADDR_W-1:2]: begin
          rdata_next = status_word;
        end
        REG_COUNT[AXI_ADDR_W-1:2]: begin
          rdata_next = count_word;
        end
        default: begin
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg     <= 1'b0;
      wready_reg      <= 1'b0;
      bvalid_reg      <= 1'b0;
      bresp_reg       <= RESP_OKAY;
      aw_have_reg     <= 1'b0;
      w_have_reg      <= 1'b0;
      aw_addr_reg     <= '0;
      w_data_reg      <= '0;
      w_strb_reg      <= '0;
      arready_reg     <= 1'b0;
      rvalid_reg      <= 1'b0;
      rresp_reg       <= RESP_OKAY;
      rdata_reg       <= '0;
      ctrl_inject_reg <= CTRL_INJECT_RESET;
    end else begin
      awready_reg     <= awready_next;
      wready_reg      <= wready_next;
      bvalid_reg      <= bvalid_next;
      bresp_reg       <= bresp_next;
      aw_have_reg     <= aw_have_next;
      w_have_reg      <= w_have_next;
      aw_addr_reg     <= aw_addr_next;
      w_data_reg      <= w_data_next;
      w_strb_reg      <= w_strb_next;
      arready_reg     <= arready_next;
      rvalid_reg      <= rvalid_next;
      rresp_reg       <= rresp_next;
      rdata_reg       <= rdata_next;
      ctrl_inject_reg <= ctrl_inject_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

endmodule

// file: eccdp_top_asserts.sv
// assertions on the user ports of the protected dual-port memory
`timescale 1ns/1ps
module eccdp_top_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       port_a_lsb_inject,
  input wire logic [7:0] port_a_wr_data,
  input wire logic       port_a_wr_en,
  input wire logic       port_a_rd_en,
  input wire logic       port_b_rd_en,
  input wire logic [7:0] port_a_read_word,
  input wire logic       port_a_fixed_flag,
  input wire logic       port_a_found_flag,
  input wire logic       port_a_uncorrectable_flag,
  input wire logic [7:0] port_b_read_word,
  input wire logic       port_b_fixed_flag,
  input wire logic       port_b_found_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_hold_a;
    !$past(port_a_rd_en, 4) |-> $stable(port_a_read_word);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("port a word moved");
  property p_hold_b;
    !$past(port_b_rd_en, 4) |-> $stable(port_b_read_word);
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("port b word moved");
  property p_fix_a;
    port_a_fixed_flag |-> port_a_found_flag;
  endproperty
  a_fix_a: assert property (p_fix_a) else $error("port a fixed alone");
  property p_fix_b;
    port_b_fixed_flag |-> port_b_found_flag;
  endproperty
  a_fix_b: assert property (p_fix_b) else $error("port b fixed alone");
  property p_unc_a;
    port_a_uncorrectable_flag |-> port_a_found_flag && !port_a_fixed_flag;
  endproperty
  a_unc_a: assert property (p_unc_a) else $error("port a fatal flags");
  property p_one_a;
    port_a_fixed_flag |-> !port_a_uncorrectable_flag;
  endproperty
  a_one_a: assert property (p_one_a) else $error("port a fixed and fatal");
  property p_rdw_a;
    $past(port_a_wr_en && port_a_rd_en, 4) |-> port_a_read_word == $past(port_a_wr_data, 4);
  endproperty
  a_rdw_a: assert property (p_rdw_a) else $error("port a rdw word");
  property p_inj;
    $past(port_a_lsb_inject && port_a_wr_en && port_a_rd_en, 4) |-> port_a_fixed_flag;
  endproperty
  a_inj: assert property (p_inj) else $error("port a inject missed");
endmodule

// file: eccdp_user.sv
// behavioural user logic driving both memory ports
`timescale 1ns/1ps
module eccdp_user (
  input wire logic  aclk,
  output logic       port_a_lsb_inject,
  output logic [3:0] port_a_addr,
  output logic [7:0] port_a_wr_data,
  output logic       port_a_wr_en,
  output logic       port_a_rd_en,
  output logic [3:0] port_b_addr,
  output logic [7:0] port_b_wr_data,
  output logic       port_b_wr_en,
  output logic       port_b_rd_en
);
  initial begin
    {port_a_lsb_inject, port_a_addr, port_a_wr_data, port_a_wr_en, port_a_rd_en} = '0;
    {port_b_addr, port_b_wr_data, port_b_wr_en, port_b_rd_en} = '0;
  end
  // idle write data toggles so a stale byte never passes for a live one
  task automatic cyc(input logic [3:0] aa, input logic [7:0] ad, input logic [2:0] ac,
                     input logic [3:0] ba, input logic [7:0] bd, input logic [1:0] bc);
    @(posedge aclk);
    port_a_addr <= aa;
    port_a_wr_data <= ac[1] ? ad : ~port_a_wr_data;
    {port_a_lsb_inject, port_a_wr_en, port_a_rd_en} <= ac;
    port_b_addr <= ba;
    port_b_wr_data <= bc[1] ? bd : ~port_b_wr_data;
    {port_b_wr_en, port_b_rd_en} <= bc;
  endtask
endmodule

// file: eccdp_top_bench.sv
// self-checking bench for the protected dual-port memory
`timescale 1ns/1ps
module eccdp_top_bench;
  import eccdp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic port_a_lsb_inject, port_a_wr_en, port_a_rd_en, port_b_wr_en, port_b_rd_en;
  logic [3:0] port_a_addr, port_b_addr;
  logic [7:0] port_a_wr_data, port_b_wr_data, port_a_read_word, port_b_read_word;
  logic port_a_fixed_flag, port_a_found_flag, port_a_uncorrectable_flag;
  logic port_b_fixed_flag, port_b_found_flag, port_b_uncorrectable_flag;
  logic [7:0] mem [16];
  logic im [16];
  logic [10:0] pa [6];
  logic [10:0] pb [6];
  logic [7:0] ca, cb;
  logic sw;
  int fail_count, checks_done;
  always #12.5 aclk = ~aclk;
  eccdp_top u_dut (.*);
  eccdp_user u_user (.*);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [10:0] ex(input logic [7:0] d, input logic i);
    return (d === 8'hXX) ? 'x : {d, i, i, 1'b0};
  endfunction
  // expected results ride a six-deep pipe; an idle slot repeats the held value
  task automatic op(input logic [3:0] aa, input logic [7:0] ad, input logic [2:0] ac,
                    input logic [3:0] ba, input logic [7:0] bd, input logic [1:0] bc);
    logic ia;
    u_user.cyc(aa, ad, ac, ba, bd, bc);
    ia = ac[2] | sw;
    for (int k = 5; k > 0; k--) begin
      pa[k] = pa[k-1];
      pb[k] = pb[k-1];
    end
    pa[0] = ac[0] ? (ac[1] ? ex(ad, ia) : ex(mem[aa], im[aa])) : pa[1];
    pb[0] = bc[0] ? ex(mem[ba], im[ba]) : pb[1];
    ca = ca + 8'(ac[0] && pa[0][2] === 1'b1);
    cb = cb + 8'(bc[0] && pb[0][2] === 1'b1);
    if (ac[1]) begin
      mem[aa] = ad;
      im[aa] = ia;
    end
    if (bc[1]) begin
      mem[ba] = (ac[1] && aa == ba) ? 8'hXX : bd;
      im[ba] = 1'b0;
    end
    #1;
    chk("port_a", {port_a_read_word, port_a_fixed_flag, port_a_found_flag,
        port_a_uncorrectable_flag}, pa[4]);
    chk("port_b", {port_b_read_word, port_b_fixed_flag, port_b_found_flag,
        port_b_uncorrectable_flag}, pb[4]);
  endtask
  task automatic ax(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w ? s_axi_bvalid : s_axi_rvalid) break;
    end
    if (n == 20) begin
      chk("bus wait", 0, 1);
      finish_test();
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
    chk("resp", 32'(w ? s_axi_bresp : s_axi_rresp), 32'(er));
    if (!w) chk("rdata", s_axi_rdata, d);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {ca, cb, sw} = '0;
    foreach (pa[k]) begin
      pa[k] = '0;
      pb[k] = '0;
    end
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      op(4'(i), 8'(8'h30 + i), 3'b010, 4'(i + 8), 8'(8'h50 + i), 2'b10);
    end
    op(4'h2, 8'hAA, 3'b011, 4'h3, 8'hBB, 2'b11);
    op(4'h2, 8'h00, 3'b001, 4'h3, 8'h00, 2'b01);
    op(4'h1, 8'hCC, 3'b010, 4'h1, 8'h00, 2'b01);
    op(4'h4, 8'h00, 3'b001, 4'h4, 8'hDD, 2'b10);
    op(4'h1, 8'h00, 3'b001, 4'h4, 8'h00, 2'b01);
    op(4'h0, 8'hFF, 3'b111, 4'h0, 8'h00, 2'b01);
    op(4'h0, 8'h00, 3'b001, 4'h0, 8'h00, 2'b01);
    op(4'h0, 8'h5A, 3'b010, 4'h5, 8'h00, 2'b01);
    for (int i = 0; i < 16; i++) begin
      op(4'(i), 8'h00, 3'b001, 4'(15 - i), 8'h00, 2'b01);
    end
    repeat (5) op(4'h0, 8'h00, 3'b000, 4'h0, 8'h00, 2'b00);
    ax(1'b0, REG_CTRL, 32'h0, RESP_OKAY);
    ax(1'b0, REG_COUNT, {16'h0, cb, ca}, RESP_OKAY);
    ax(1'b1, 4'hC, 32'h1, RESP_SLVERR);
    ax(1'b0, 4'hC, 32'h0, RESP_SLVERR);
    ax(1'b1, REG_CTRL, 32'h1, RESP_OKAY);
    ax(1'b0, REG_CTRL, 32'h1, RESP_OKAY);
    sw = 1'b1;
    op(4'h6, 8'h66, 3'b010, 4'h0, 8'h00, 2'b00);
    sw = 1'b0;
    op(4'h6, 8'h00, 3'b001, 4'h6, 8'h00, 2'b01);
    repeat (5) op(4'h0, 8'h00, 3'b000, 4'h0, 8'h00, 2'b00);
    ax(1'b1, REG_CTRL, 32'h0, RESP_OKAY);
    ax(1'b0, REG_COUNT, {16'h0, cb, ca}, RESP_OKAY);
    ax(1'b0, REG_STATUS, 32'h33, RESP_OKAY);
    ax(1'b1, REG_COUNT, 32'h0, RESP_OKAY);
    ax(1'b0, REG_COUNT, 32'h0, RESP_OKAY);
    op(4'h9, 8'h11, 3'b010, 4'h9, 8'h22, 2'b10);
    repeat (6) op(4'h9, 8'h00, 3'b001, 4'h9, 8'h00, 2'b01);
    finish_test();
  end
endmodule
bind eccdp_top eccdp_top_asserts u_chk (.aclk, .aresetn, .port_a_lsb_inject, .port_a_wr_data,
  .port_a_wr_en, .port_a_rd_en, .port_b_rd_en, .port_a_read_word, .port_a_fixed_flag,
  .port_a_found_flag, .port_a_uncorrectable_flag, .port_b_read_word, .port_b_fixed_flag,
  .port_b_found_flag);
